// file: swf_pkg.sv
// Package for the sampler writeback formatter.
// Assumes one 100 MHz clock shared by the APB slave, request source and register file.
package swf_pkg;

    // ************************************************************
    // Register map and reset values
    // ************************************************************
    localparam logic [11:0] SWF_OFS_CTRL     = 12'h000;
    localparam logic [11:0] SWF_OFS_STATUS   = 12'h004;
    localparam logic [11:0] SWF_OFS_COUNT    = 12'h008;
    localparam logic [31:0] SWF_CTRL_RESET   = 32'h0000_0001;
    localparam int          SWF_CTRL_ENABLE  = 0;
    localparam int          SWF_STAT_BUSY    = 0;

    // ************************************************************
    // Message layout constants
    // ************************************************************
    localparam int          SWF_NUM_SLOTS    = 9;
    localparam int          SWF_FAULT16_SLOT = 8;
    localparam int          SWF_KILL8_SLOT   = 4;
    localparam int          SWF_FAULT8_SLOT  = 5;
    localparam int          SWF_FAULT42_SLOT = 1;
    localparam logic [15:0] SWF_ONES16       = 16'hffff;
    localparam logic [23:0] SWF_ONES24       = 24'hffffff;
    localparam logic [29:0] SWF_ONES30       = 30'h3fffffff;
    localparam logic [7:0]  SWF_ONES8        = 8'hff;
    localparam logic [7:0]  SWF_DW0_ONLY     = 8'h01;

    typedef enum logic [1:0] {
        SWF_SIXTEEN_PIXEL,
        SWF_EIGHT_PIXEL,
        SWF_TWO_SAMPLE,
        SWF_WIDE
    } swf_layout_t;

    typedef enum logic {
        SWF_IDLE,
        SWF_EMIT
    } swf_state_t;

    // Request: channel mask bit set means the channel is masked off.
    typedef struct packed {
        swf_layout_t               layout;
        logic [3:0]                chanMask;
        logic [15:0]               execMask;
        logic                      killVariant;
        logic                      faultEnable;
        logic [15:0]               activeMask;
        logic [15:0]               nullMask;
        logic [3:0][15:0][31:0]    chanData;
    } swf_req_t;

    typedef struct packed {
        logic                      present;
        logic [7:0]                enable;
        logic [7:0][31:0]          data;
    } swf_beat_t;

    typedef struct packed {
        logic                      valid;
        logic [3:0]                index;
        logic [7:0]                enable;
        logic [7:0][31:0]          data;
        logic                      last;
    } swf_wb_t;

endpackage

// file: swf_formatter.sv
// Sampler writeback formatter: turns one sampling request into its destination register writes.
// Assumes the request source and register file share clk and the register file takes one
// register per cycle without stalling.
`timescale 1ns/1ps

// Behaviour
// - Every accepted request yields exactly one message in the layout of its type; wide requests use the sixteen-pixel layout.
// - Sixteen-pixel results carry at most eight data registers, chosen by channel mask.
// - Masked sixteen-pixel channels are skipped; later channels move down to close the gap.
// - Sixteen-pixel data dwords are written only where their execution mask bit is set.
// - Sixteen-pixel channel uses two registers, subspans 0-1 then 2-3, order RGBA.
// - Channel dwords pass through in the surface's float, signed or unsigned format.
// - Sixteen-pixel fault register: dword 0 only, upper ones, low sixteen null-mask bits.
// - Null mask bit is one unless a texel of that pixel came from a null page.
// - Eight-pixel results return all four channels but masked channels write nothing.
// - Eight-pixel registers 0 to 3 hold red to alpha, dword equals pixel index.
// - Kill-mask eight-pixel request appends fifth register, dword 0 only, upper ones.
// - Kill dword low eight bits are one per surviving pixel; high twenty-four bits always one.
// - Eight-pixel fault register: dword 0, bits 31:8 ones, bits 7:0 null mask.
// - Four-by-two result is one register, sample 0 in dwords 0-3, sample 1 in 4-7.
// - Sample active if any of its four exec bits set; write enabled channels only.
// - Four-by-two fault register: dword 0, bits 31:2 ones, bits 1:0 null mask.
module swf_formatter (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              reqValid,
    input  swf_pkg::swf_req_t      reqIn,
    output logic                   reqReady,
    output swf_pkg::swf_wb_t       wbOut,
    output logic                   msgDone
);
    import swf_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        swf_state_t                 state;
        swf_req_t                   req;
        logic [SWF_NUM_SLOTS-1:0]   presVec;
        logic [3:0]                 slot;
        logic [3:0]                 index;
        logic [31:0]                ctrl;
        logic [31:0]                count;
        logic                       pready;
        logic [31:0]                prdata;
        logic                       pslverr;
        logic                       reqReady;
        swf_wb_t                    wb;
        logic                       msgDone;
    } swf_regs_t;

    swf_regs_t regs_q;
    swf_regs_t regs_d;

    // ************************************************************
    // Contents of one layout slot
    // ************************************************************
    function automatic swf_beat_t slotBeat(input swf_req_t r, input logic [3:0] slot);
        swf_beat_t  b;
        logic [1:0] ch;
        logic       half;
        logic       act;
        b = '0;
        ch = slot[2:1];
        half = slot[0];
        act = 1'b0;
        case (r.layout)
            SWF_EIGHT_PIXEL:
            begin
                if (slot < 4'(SWF_KILL8_SLOT))
                begin
                    b.present = 1'b1;
                    for (int i = 0; i < 8; i++)
                    begin
                        b.data[i] = r.chanData[slot[1:0]][i];
                        b.enable[i] = r.execMask[i] & ~r.chanMask[slot[1:0]];
                    end
                end
                else if (slot == 4'(SWF_KILL8_SLOT))
                begin
                    b.present = r.killVariant;
                    b.enable = SWF_DW0_ONLY;
                    b.data[0] = {SWF_ONES16, SWF_ONES8, r.activeMask[7:0]};
                end
                else if (slot == 4'(SWF_FAULT8_SLOT))
                begin
                    b.present = r.faultEnable;
                    b.enable = SWF_DW0_ONLY;
                    b.data[0] = {SWF_ONES24, r.nullMask[7:0]};
                end
            end
            SWF_TWO_SAMPLE:
            begin
                if (slot == 4'd0)
                begin
                    b.present = 1'b1;
                    for (int i = 0; i < 8; i++)
                    begin
                        act = (i < 4) ? |r.execMask[3:0] : |r.execMask[7:4];
                        b.data[i] = r.chanData[i % 4][i / 4];
                        b.enable[i] = act & ~r.chanMask[i % 4];
                    end
                end
                else if (slot == 4'(SWF_FAULT42_SLOT))
                begin
                    b.present = r.faultEnable;
                    b.enable = SWF_DW0_ONLY;
                    b.data[0] = {SWF_ONES30, r.nullMask[1:0]};
                end
            end
            default:
            begin
                if (slot < 4'(SWF_FAULT16_SLOT))
                begin
                    b.present = ~r.chanMask[ch];
                    for (int i = 0; i < 8; i++)
                    begin
                        b.data[i] = r.chanData[ch][{half, 3'(i)}];
                        b.enable[i] = r.execMask[{half, 3'(i)}];
                    end
                end
                else if (slot == 4'(SWF_FAULT16_SLOT))
                begin
                    b.present = r.faultEnable;
                    b.enable = SWF_DW0_ONLY;
                    b.data[0] = {SWF_ONES16, r.nullMask};
                end
            end
        endcase
        return b;
    endfunction

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        logic [SWF_NUM_SLOTS-1:0] pres;
        logic [3:0]               first;
        logic [3:0]               nxt;
        logic                     found;
        logic                     access;
        swf_beat_t                beat;
        pres = '0;
        first = '0;
        nxt = '0;
        found = 1'b0;
        access = 1'b0;
        beat = '0;
        regs_d = regs_q;
        regs_d.wb.valid = 1'b0;
        regs_d.wb.last = 1'b0;
        regs_d.msgDone = 1'b0;
        regs_d.pready = 1'b0;

        // APB slave: answer on the second access cycle.
        access = psel & penable & ~regs_q.pready;
        if (access)
        begin
            regs_d.pready = 1'b1;
            regs_d.pslverr = 1'b0;
            regs_d.prdata = '0;
            case (paddr)
                SWF_OFS_CTRL:
                begin
                    if (pwrite)
                    begin
                        regs_d.ctrl = {31'h0, pwdata[SWF_CTRL_ENABLE]};
                    end
                    regs_d.prdata = regs_q.ctrl;
                end
                SWF_OFS_STATUS:
                begin
                    regs_d.prdata[SWF_STAT_BUSY] = (regs_q.state == SWF_EMIT);
                end
                SWF_OFS_COUNT:
                begin
                    if (pwrite)
                    begin
                        regs_d.count = '0;
                    end
                    regs_d.prdata = regs_q.count;
                end
                default:
                begin
                    regs_d.pslverr = 1'b1;
                end
            endcase
        end

        case (regs_q.state)
            SWF_IDLE:
            begin
                if (reqValid && regs_q.reqReady)
                begin
                    for (int k = SWF_NUM_SLOTS - 1; k >= 0; k--)
                    begin
                        beat = slotBeat(reqIn, 4'(k));
                        pres[k] = beat.present;
                        if (pres[k])
                        begin
                            first = 4'(k);
                        end
                    end
                    regs_d.req = reqIn;
                    regs_d.presVec = pres;
                    regs_d.slot = first;
                    regs_d.index = '0;
                    if (pres == '0)
                    begin
                        regs_d.msgDone = 1'b1;
                        regs_d.count = regs_d.count + 32'h1;
                    end
                    else
                    begin
                        regs_d.state = SWF_EMIT;
                        regs_d.reqReady = 1'b0;
                    end
                end
                else
                begin
                    regs_d.reqReady = regs_q.ctrl[SWF_CTRL_ENABLE];
                end
            end
            SWF_EMIT:
            begin
                beat = slotBeat(regs_q.req, regs_q.slot);
                for (int k = SWF_NUM_SLOTS - 1; k >= 0; k--)
                begin
                    if (k > int'(regs_q.slot) && regs_q.presVec[k])
                    begin
                        nxt = 4'(k);
                        found = 1'b1;
                    end
                end
                regs_d.wb.valid = 1'b1;
                regs_d.wb.index = regs_q.index;
                regs_d.wb.enable = beat.enable;
                regs_d.wb.data = beat.data;
                regs_d.wb.last = ~found;
                regs_d.index = regs_q.index + 4'h1;
                regs_d.slot = nxt;
                if (!found)
                begin
                    regs_d.msgDone = 1'b1;
                    regs_d.count = regs_d.count + 32'h1;
                    regs_d.state = SWF_IDLE;
                end
            end
            default:
            begin
                regs_d.state = SWF_IDLE;
            end
        endcase
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            regs_q <= '0;
            regs_q.state <= SWF_IDLE;
            regs_q.ctrl <= SWF_CTRL_RESET;
        end
        else
        begin
            regs_q <= regs_d;
        end
    end

    assign pready   = regs_q.pready;
    assign prdata   = regs_q.prdata;
    assign pslverr  = regs_q.pslverr;
    assign reqReady = regs_q.reqReady;
    assign wbOut    = regs_q.wb;
    assign msgDone  = regs_q.msgDone;

endmodule

// file: swf_monitor.sv
// Concurrent checks on the writeback formatter request and writeback ports.
// Assumes it is bound to swf_formatter and shares its clock and reset.
`timescale 1ns/1ps
module swf_monitor (
    input wire logic         clk,
    input wire logic         reset_n,
    input wire logic         reqValid,
    input swf_pkg::swf_req_t reqIn,
    input wire logic         reqReady,
    input swf_pkg::swf_wb_t  wbOut,
    input wire logic         msgDone
);
    import swf_pkg::*;
    // ****************************************
    // Held request and properties
    // ****************************************
    swf_req_t heldReq_q;
    always_ff @(posedge clk or negedge reset_n)
        if (!reset_n)
            heldReq_q <= '0;
        else if (reqValid && reqReady)
            heldReq_q <= reqIn;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_LAST_DONE: assert property (wbOut.valid && wbOut.last |-> msgDone)
        else $error("last beat without done");
    AST_ACCEPT_ANSWER: assert property (reqValid && reqReady |-> ##[1:2]
        ((wbOut.valid && wbOut.index == 4'h0) || msgDone)) else $error("no answer");
    AST_BUSY_REFUSE: assert property (wbOut.valid |-> !reqReady)
        else $error("ready while emitting");
    AST_INDEX_STEP: assert property (wbOut.valid && !wbOut.last |=>
        wbOut.valid && wbOut.index == $past(wbOut.index) + 4'h1) else $error("index gap");
    AST_MAX_INDEX: assert property (wbOut.valid |-> wbOut.index <= 4'h8)
        else $error("too many registers");
    AST_EXEC16: assert property (wbOut.valid && heldReq_q.layout == SWF_SIXTEEN_PIXEL
        && !(heldReq_q.faultEnable && wbOut.last) |-> wbOut.enable == heldReq_q.execMask[7:0]
        || wbOut.enable == heldReq_q.execMask[15:8]) else $error("bad enable");
    AST_KILL_WORD: assert property (wbOut.valid && heldReq_q.layout == SWF_EIGHT_PIXEL
        && heldReq_q.killVariant && wbOut.index == 4'h4 |-> wbOut.enable == 8'h01
        && wbOut.data[0] == {16'hffff, 8'hff, heldReq_q.activeMask[7:0]}) else $error("kill");
    AST_TWO_ONE: assert property (wbOut.valid && heldReq_q.layout == SWF_TWO_SAMPLE
        |-> wbOut.index <= 4'h1 && wbOut.last == (wbOut.index == {3'h0,
        heldReq_q.faultEnable})) else $error("two sample length");
    AST_EIGHT_FOUR: assert property (wbOut.valid && heldReq_q.layout == SWF_EIGHT_PIXEL
        && wbOut.index < 4'h4 |-> !wbOut.last) else $error("eight pixel short");
endmodule

bind swf_formatter swf_monitor u_swf_monitor (.clk(clk), .reset_n(reset_n),
    .reqValid(reqValid), .reqIn(reqIn), .reqReady(reqReady), .wbOut(wbOut),
    .msgDone(msgDone));

// file: swf_regfile_model.sv
// Destination register file model that takes writeback beats.
// Assumes beats arrive one per cycle; clearMem refills a known pattern.
`timescale 1ns/1ps
module swf_regfile_model (
    input wire logic              clk,
    input wire logic              clearMem,
    input swf_pkg::swf_wb_t       wbIn,
    output logic [9:0][7:0][31:0] regFile,
    output logic [3:0]            beatCount
);
    import swf_pkg::*;
    // ****************************************
    // Register writes
    // ****************************************
    always_ff @(posedge clk)
        if (clearMem)
        begin
            regFile <= {80{32'ha5a5a5a5}};
            beatCount <= 4'h0;
        end
        else if (wbIn.valid)
        begin
            beatCount <= beatCount + 4'h1;
            for (int d = 0; d < 8; d++)
                if (wbIn.enable[d] && wbIn.index < 4'ha)
                    regFile[wbIn.index][d] <= wbIn.data[d];
        end
endmodule

// file: test_sampler_writeback_formatter.sv
// Testbench for the writeback formatter: APB accesses and request table.
// Assumes swf_pkg, swf_monitor and swf_regfile_model are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin errTotal++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module test_sampler_writeback_formatter;
    import swf_pkg::*;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic clk, reset_n, psel, penable, pwrite, pready, pslverr, reqValid, reqReady, msgDone;
    logic clearMem;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdV;
    logic errV;
    swf_req_t reqIn, r;
    swf_wb_t wbOut;
    logic [9:0][7:0][31:0] regFile, ex;
    logic [3:0] beatCount;
    int errTotal, numChecks, n;
    logic [1:0] tLay[9] = '{2'h0, 2'h0, 2'h3, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h1};
    logic [3:0] tMsk[9] = '{4'h6, 4'h0, 4'h8, 4'h5, 4'h0, 4'h2, 4'h0, 4'hf, 4'ha};
    logic [15:0] tExe[9] = '{16'hffff, 16'h0f3c, 16'hff00, 16'h00c3, 16'h00ff,
        16'h00f0, 16'h0001, 16'hffff, 16'h0081};
    logic [1:0] tFk[9] = '{2'h0, 2'h1, 2'h1, 2'h3, 2'h2, 2'h1, 2'h0, 2'h0, 2'h1};
    swf_formatter u_swf_formatter (.clk(clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .reqValid(reqValid), .reqIn(reqIn),
        .reqReady(reqReady), .wbOut(wbOut), .msgDone(msgDone));
    swf_regfile_model u_swf_regfile_model (.clk(clk), .clearMem(clearMem), .wbIn(wbOut),
        .regFile(regFile), .beatCount(beatCount));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic conclude();
        $display("Checks %0d, errors %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (!pready);
        rdV = prdata;
        errV = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic send(input swf_req_t q);
        int t;
        reqIn <= q;
        reqValid <= 1'b1;
        t = 0;
        do begin @(posedge clk); t++; end while (!reqReady && t < 50);
        reqValid <= 1'b0;
        while (!msgDone && t < 100) begin @(posedge clk); t++; end
        @(posedge clk);
        if (t >= 100) `CHK(1'b0, 1'b1)
    endtask
    function automatic int build(input swf_req_t q, output logic [9:0][7:0][31:0] e);
        int k;
        k = 0;
        e = {80{32'ha5a5a5a5}};
        if (q.layout == SWF_EIGHT_PIXEL)
        begin
            for (int c = 0; c < 4; c++)
                for (int d = 0; d < 8; d++)
                    if (q.execMask[d] && !q.chanMask[c]) e[c][d] = q.chanData[c][d];
            k = 4;
            if (q.killVariant)
            begin
                e[k][0] = {16'hffff, 8'hff, q.activeMask[7:0]};
                k++;
            end
            if (q.faultEnable)
            begin
                e[k][0] = {24'hffffff, q.nullMask[7:0]};
                k++;
            end
        end
        else if (q.layout == SWF_TWO_SAMPLE)
        begin
            for (int i = 0; i < 8; i++)
                if (|q.execMask[(i/4)*4 +: 4] && !q.chanMask[i%4])
                    e[0][i] = q.chanData[i%4][i/4];
            k = 1;
            if (q.faultEnable)
            begin
                e[k][0] = {30'h3fffffff, q.nullMask[1:0]};
                k++;
            end
        end
        else
        begin
            for (int c = 0; c < 4; c++)
                if (!q.chanMask[c])
                    for (int h = 0; h < 2; h++)
                    begin
                        for (int d = 0; d < 8; d++)
                            if (q.execMask[h*8+d]) e[k][d] = q.chanData[c][h*8+d];
                        k++;
                    end
            if (q.faultEnable)
            begin
                e[k][0] = {16'hffff, q.nullMask};
                k++;
            end
        end
        return k;
    endfunction
    // ****************************************
    // Sequence
    // ****************************************
    initial
    begin
        repeat (5000) @(posedge clk);
        errTotal++;
        conclude();
    end
    initial
    begin
        {reset_n, psel, penable, pwrite, reqValid, clearMem} = '0;
        {paddr, pwdata, reqIn, errTotal, numChecks} = '0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, SWF_OFS_CTRL, 32'h0);
        `CHK(rdV, SWF_CTRL_RESET)
        for (int i = 0; i < 9; i++)
        begin
            r = '0;
            r.layout = swf_layout_t'(tLay[i]);
            r.chanMask = tMsk[i];
            r.execMask = tExe[i];
            {r.killVariant, r.faultEnable} = tFk[i];
            r.activeMask = 16'h005a;
            r.nullMask = 16'hbe3d;
            for (int c = 0; c < 4; c++)
                for (int p = 0; p < 16; p++) r.chanData[c][p] = {8'(i), 8'(c), 8'(p), 8'h5a};
            clearMem <= 1'b1;
            @(posedge clk);
            clearMem <= 1'b0;
            send(r);
            n = build(r, ex);
            `CHK(beatCount, 4'(n))
            for (int j = 0; j < 10; j++) `CHK(regFile[j], ex[j])
        end
        apb(1'b0, SWF_OFS_COUNT, 32'h0);
        `CHK(rdV, 32'h9)
        apb(1'b1, SWF_OFS_COUNT, 32'h0);
        apb(1'b0, SWF_OFS_COUNT, 32'h0);
        `CHK(rdV, 32'h0)
        apb(1'b1, SWF_OFS_STATUS, 32'h1);
        apb(1'b0, SWF_OFS_STATUS, 32'h0);
        `CHK(rdV[SWF_STAT_BUSY], 1'b0)
        apb(1'b0, 12'h0fc, 32'h0);
        `CHK({errV, rdV}, {1'b1, 32'h0})
        apb(1'b1, SWF_OFS_CTRL, 32'h0);
        `CHK(reqReady, 1'b0)
        apb(1'b0, SWF_OFS_CTRL, 32'h0);
        `CHK(rdV, 32'h0)
        apb(1'b1, SWF_OFS_CTRL, 32'h1);
        apb(1'b0, SWF_OFS_CTRL, 32'h0);
        `CHK(rdV[SWF_CTRL_ENABLE], 1'b1)
        conclude();
    end
endmodule
